// ### radio_rate_test_state_regs_tb_top.sv
// Self-checking testbench for the rate, settle, test and readout registers.
`timescale 1ns/1ps
module radio_rate_test_state_regs_tb_top;
  import rrt_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, reg_hit, osc_restart = 1'b0, clk_stable, adc_clk_high;
  logic [6:0] load_cap_trim;
  logic [2:0] base_rate_sel = 3'h0, rate_sel_out, test_pattern;
  logic       base_tick = 1'b0, frac_enable = 1'b0, rate_tick;
  logic       test_active, carrier_on, test_bit, preamble_match = 1'b0, state_code_known;
  logic [4:0] frame_engine_state = 5'h00;
  int         errors = 0;
  int         samples_checked = 0;

  // Clock at 125 MHz.
  always #4 clk = ~clk;

  rrt_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Short settle counts keep the run brief.
  rrt_regs #(.SETTLE_00_CYC(40), .SETTLE_01_CYC(26), .SETTLE_10_CYC(20), .SETTLE_11_CYC(12))
  dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .osc_restart(osc_restart),
    .clk_stable(clk_stable), .adc_clk_high(adc_clk_high), .load_cap_trim(load_cap_trim),
    .base_rate_sel(base_rate_sel), .base_tick(base_tick), .frac_enable(frac_enable),
    .rate_tick(rate_tick), .rate_sel_out(rate_sel_out), .test_active(test_active),
    .carrier_on(carrier_on), .test_bit(test_bit), .test_pattern(test_pattern),
    .frame_engine_state(frame_engine_state), .preamble_match(preamble_match),
    .state_code_known(state_code_known));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One base pulse; the rate output is looked at while the pulse stands.
  task automatic pulse(output logic r);
    @(negedge clk);
    base_tick = 1'b1;
    #1 r = rate_tick;
    @(negedge clk);
    base_tick = 0;
    @(negedge clk);
  endtask

  task automatic t_reset();
    logic [6:0] ofs [6] = '{7'h04, 7'h05, 7'h08, 7'h0b, 7'h0c, 7'h0f};
    logic [7:0] rst [6] = '{8'h00, 8'h00, 8'hc3, 8'h40, 8'h00, 8'hc0};
    logic [7:0] d;
    foreach (ofs[i])
    begin
      u_host.rd(ofs[i], d);
      chk({reg_hit, d}, {1'b1, rst[i]});
    end
    u_host.rd(7'h06, d);
    chk({reg_hit, d}, 9'h000);
    u_host.wr(7'h0b, 8'hff);
    u_host.rd(7'h0b, d);
    chk({load_cap_trim, d}, {7'h77, 8'hf7});
    $display("test reset done");
  endtask

  task automatic t_rate();
    logic [7:0] mt [5] = '{8'h02, 8'h00, 8'h00, 8'h01, 8'h00};
    logic [7:0] dv [5] = '{8'h03, 8'h04, 8'h09, 8'h04, 8'h00};
    logic r;
    int n;
    for (int s = 0; s < 8; s++)
    begin
      @(negedge clk);
      base_rate_sel = s[2:0];
      #1 chk(rate_sel_out, s[2:0]);
    end
    @(negedge clk);
    base_rate_sel = 3'h2;
    foreach (mt[i])
    begin
      frac_enable = 1'b1;
      u_host.wr(7'h05, 8'h00);
      u_host.wr(7'h04, 8'h00);
      pulse(r);
      u_host.wr(7'h04, mt[i]);
      u_host.wr(7'h05, dv[i]);
      n = 0;
      repeat (4 * (dv[i] + 1))
      begin
        pulse(r);
        n += r;
      end
      chk(n, 4 * (mt[i] + 1));
    end
    frac_enable = 1'b0;
    u_host.wr(7'h05, 8'h09);
    n = 0;
    repeat (10)
    begin
      pulse(r);
      n += r;
    end
    chk(n, 10);
    $display("test rate done");
  endtask

  task automatic t_settle();
    int lim [4] = '{40, 26, 20, 12};
    logic [7:0] d;
    int cnt;
    for (int f = 0; f < 4; f++)
    begin
      u_host.wr(7'h08, {f[1:0], 2'b11, 4'h3});
      @(negedge clk);
      osc_restart = 1'b1;
      @(negedge clk);
      osc_restart = 1'b0;
      cnt = 1;
      while (clk_stable !== 1'b1 && cnt < 200)
      begin
        @(negedge clk);
        cnt++;
      end
      chk(cnt >= lim[f] && cnt <= lim[f] + 2, 1'b1);
      u_host.rd(7'h08, d);
      chk({adc_clk_high, d}, {1'b1, f[1:0], 6'h13});
    end
    u_host.wr(7'h08, 8'hc3);
    @(negedge clk);
    chk(adc_clk_high, 1'b0);
    $display("test settle done");
  endtask

  task automatic t_test();
    int bitpos [6] = '{1, 2, 3, 4, 5, 7};
    logic [2:0] code [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    logic b [30];
    logic r, bad;
    foreach (bitpos[i])
    begin
      u_host.wr(7'h0c, 8'h01 | (8'h01 << bitpos[i]));
      repeat (2) @(negedge clk);
      chk({test_active, carrier_on, test_pattern}, {1'b1, code[i] == 3'h5, code[i]});
    end
    u_host.wr(7'h0c, 8'hfe);
    repeat (2) @(negedge clk);
    pulse(r);
    chk({test_active, test_bit}, 2'b00);
    u_host.wr(7'h0c, 8'hff);
    repeat (2) @(negedge clk);
    chk(test_pattern, RRT_PAT_PN9);
    for (int k = 4; k < 6; k++)
    begin
      u_host.wr(7'h0c, k == 4 ? 8'h03 : 8'h81);
      repeat (2) pulse(r);
      foreach (b[i])
      begin
        pulse(r);
        b[i] = test_bit;
      end
      bad = 1'b0;
      for (int n = 0; n < 21; n++)
        bad |= b[n + 9] !== (b[n] ^ b[n + k]);
      chk(bad, 1'b0);
    end
    u_host.wr(7'h0c, 8'h05);
    repeat (2) pulse(r);
    chk(test_bit, 1'b1);
    u_host.wr(7'h0c, 8'h09);
    repeat (2) pulse(r);
    chk(test_bit, 1'b0);
    // The alternating pattern must flip on every base pulse.
    u_host.wr(7'h0c, 8'h11);
    pulse(r);
    b[0] = test_bit;
    pulse(r);
    b[1] = test_bit;
    chk(b[0] ^ b[1], 1'b1);
    u_host.wr(7'h0c, 8'h00);
    $display("test pattern done");
  endtask

  task automatic t_state();
    logic [4:0] cs [21] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
      5'h09, 5'h0b, 5'h11, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1c, 5'h1d, 5'h1f};
    logic [7:0] d;
    u_host.wr(7'h0f, 8'h3f);
    foreach (cs[i])
    begin
      @(negedge clk);
      frame_engine_state = cs[i];
      preamble_match = i[0];
      repeat (3) @(negedge clk);
      u_host.rd(7'h0f, d);
      chk({state_code_known, d}, {1'b1, 2'b00, i[0], cs[i]});
    end
    frame_engine_state = 5'h0a;
    repeat (4) @(negedge clk);
    u_host.rd(7'h0f, d);
    u_host.rd(7'h0f, d);
    chk({state_code_known, d}, {1'b0, 8'h0a});
    $display("test state done");
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence after a 16-cycle reset.
  initial
  begin
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_rate();
    t_settle();
    t_test();
    t_state();
    summarize();
  end

  // Watchdog, well beyond the roughly one thousand cycles the tests take.
  initial
  begin
    #400_000;
    errors++;
    summarize();
  end
endmodule

// ### rrt_host_model.sv
// Host-side model that drives the byte-wide register strobe port.
`timescale 1ns/1ps
module rrt_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic [6:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle lines show the inverse of the last transfer so no stale value looks valid.
  initial
  begin
    reg_addr = 7'h7f;
    reg_wdata = 8'hff;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One write; only register access is made, never an RF command.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 7'h0b && d[6:0] > 7'h77) ? {d[7], 7'h77} : d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask

  // One read; the byte is taken in the cycle after the strobe edge.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
    reg_addr = ~a;
  endtask
endmodule

// ### rrt_pattern_gen.sv
// Transmit test-pattern generator with standard and meter-style PN9.
`timescale 1ns/1ps
module rrt_pattern_gen
  import rrt_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic [2:0] pat_sel,
  input  wire logic       bit_tick,
  // Output
  output logic            pat_bit
);

  logic [8:0] lfsr_reg;
  logic [8:0] lfsr_next;
  logic       fb;
  logic       alt_reg;
  logic       bit_next;
  logic       bit_reg;

  // Standard taps stages 9 and 5; the meter variant feeds stage 4 into the XOR.
  assign fb = (pat_sel == RRT_PAT_MPN9) ? (lfsr_reg[8] ^ lfsr_reg[3])
                                        : (lfsr_reg[8] ^ lfsr_reg[4]);
  assign lfsr_next = {lfsr_reg[7:0], fb};
  assign bit_next  = (pat_sel == RRT_PAT_PN9 || pat_sel == RRT_PAT_MPN9) ? lfsr_reg[8] :
                     (pat_sel == RRT_PAT_ONES) ? 1'b1 :
                     (pat_sel == RRT_PAT_ALT)  ? alt_reg : 1'b0;

  // One bit per tick; idle selection keeps the register at its seed.
  always_ff @(posedge clk)
  begin
    if (!nrst || pat_sel == RRT_PAT_NONE)
    begin
      lfsr_reg <= RRT_PN9_SEED;
      alt_reg  <= 1'b0;
      bit_reg  <= 1'b0;
    end
    else if (bit_tick)
    begin
      lfsr_reg <= lfsr_next;
      alt_reg  <= ~alt_reg;
      bit_reg  <= bit_next;
    end
  end

  assign pat_bit = bit_reg;

endmodule

// ### rrt_pkg.sv
// Shared constants for the rate, test-pattern and state-readout register slice.
package rrt_pkg;

  // Register offsets in bank 0.
  localparam logic [6:0] RRT_OFS_MULT   = 7'h04;
  localparam logic [6:0] RRT_OFS_DIV    = 7'h05;
  localparam logic [6:0] RRT_OFS_SETTLE = 7'h08;
  localparam logic [6:0] RRT_OFS_TRIM   = 7'h0b;
  localparam logic [6:0] RRT_OFS_TEST   = 7'h0c;
  localparam logic [6:0] RRT_OFS_STATE  = 7'h0f;

  // Values after reset.
  localparam logic [7:0] RRT_RST_MULT   = 8'h00;
  localparam logic [7:0] RRT_RST_DIV    = 8'h00;
  localparam logic [7:0] RRT_RST_SETTLE = 8'hc3;
  localparam logic [7:0] RRT_RST_TRIM   = 8'h40;
  localparam logic [7:0] RRT_RST_TEST   = 8'h00;
  localparam logic [7:0] RRT_RST_STATE  = 8'hc0;

  // Field positions.
  localparam int RRT_SETTLE_SEL_LSB = 6;
  localparam int RRT_ADC_CLK_BIT    = 4;
  localparam int RRT_PREAMBLE_BIT   = 5;
  localparam int RRT_TEST_EN_BIT    = 0;

  // Mask of the writable bits in the settle register; bit 5 is reserved and reads zero.
  localparam logic [7:0] RRT_SETTLE_WMASK = 8'hdf;

  // Test pattern selections, by bit of the test pattern register.
  localparam logic [2:0] RRT_PAT_NONE    = 3'h0;
  localparam logic [2:0] RRT_PAT_PN9     = 3'h1;
  localparam logic [2:0] RRT_PAT_ONES    = 3'h2;
  localparam logic [2:0] RRT_PAT_ZEROS   = 3'h3;
  localparam logic [2:0] RRT_PAT_ALT     = 3'h4;
  localparam logic [2:0] RRT_PAT_CARRIER = 3'h5;
  localparam logic [2:0] RRT_PAT_MPN9    = 3'h7;

  // Seed of the nine-stage pseudo-random shift register.
  localparam logic [8:0] RRT_PN9_SEED = 9'h1ff;

  // Frame engine state codes.
  localparam logic [4:0] RRT_ST_IDLE     = 5'h00;
  localparam logic [4:0] RRT_ST_TX_DATAW = 5'h01;
  localparam logic [4:0] RRT_ST_TX_PRE   = 5'h02;
  localparam logic [4:0] RRT_ST_TX_SFD   = 5'h03;
  localparam logic [4:0] RRT_ST_TX_LEN   = 5'h04;
  localparam logic [4:0] RRT_ST_TX_PAY   = 5'h05;
  localparam logic [4:0] RRT_ST_TX_CRC   = 5'h06;
  localparam logic [4:0] RRT_ST_TX_POST  = 5'h07;
  localparam logic [4:0] RRT_ST_TX_OFF   = 5'h08;
  localparam logic [4:0] RRT_ST_TX_DIO   = 5'h09;
  localparam logic [4:0] RRT_ST_TX_DONE  = 5'h0b;
  localparam logic [4:0] RRT_ST_RX_SFDW  = 5'h11;
  localparam logic [4:0] RRT_ST_RX_LEN   = 5'h14;
  localparam logic [4:0] RRT_ST_RX_PAY   = 5'h15;
  localparam logic [4:0] RRT_ST_RX_CRC   = 5'h16;
  localparam logic [4:0] RRT_ST_RX_POST  = 5'h17;
  localparam logic [4:0] RRT_ST_RX_OFF   = 5'h18;
  localparam logic [4:0] RRT_ST_RX_DIO   = 5'h19;
  localparam logic [4:0] RRT_ST_RX_DIV1  = 5'h1c;
  localparam logic [4:0] RRT_ST_RX_DIV2  = 5'h1d;
  localparam logic [4:0] RRT_ST_RX_FEC   = 5'h1f;

  // Clock rate and oscillator settle times in microseconds.
  localparam int RRT_CLK_MHZ      = 125;
  localparam int RRT_SETTLE_00_US = 2000;
  localparam int RRT_SETTLE_01_US = 1300;
  localparam int RRT_SETTLE_10_US = 1000;
  localparam int RRT_SETTLE_11_US = 600;
  localparam int RRT_SETTLE_00_CYC = RRT_SETTLE_00_US * RRT_CLK_MHZ;
  localparam int RRT_SETTLE_01_CYC = RRT_SETTLE_01_US * RRT_CLK_MHZ;
  localparam int RRT_SETTLE_10_CYC = RRT_SETTLE_10_US * RRT_CLK_MHZ;
  localparam int RRT_SETTLE_11_CYC = RRT_SETTLE_11_US * RRT_CLK_MHZ;
  localparam int RRT_SETTLE_W      = 18;

  // Signal-strength converter clock choices in kHz.
  localparam int RRT_ADC_KHZ_LOW  = 1800;
  localparam int RRT_ADC_KHZ_HIGH = 2000;

  // Settle timer states.
  typedef enum logic [1:0] {RRT_OSC_WAIT, RRT_OSC_STABLE} rrt_osc_e;

endpackage

// ### rrt_rate_gate.sv
// Fractional rate converter that gates base-rate pulses with a period counter.
`timescale 1ns/1ps
module rrt_rate_gate (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Settings
  input  wire logic [7:0] mult,
  input  wire logic [7:0] div,
  // Pulses
  input  wire logic       base_tick,
  output logic            rate_tick
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       pass;

  // The counter wraps after div; a pulse passes while the count is at most mult.
  // Passed pulses bunch at the start of the period, hence the jitter.
  assign cnt_next  = (cnt_reg >= div) ? 8'h00 : cnt_reg + 8'h01;
  assign pass      = ({1'b0, cnt_reg} < ({1'b0, mult} + 9'h001));
  assign rate_tick = base_tick && pass;

  // Advance only on base pulses.
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cnt_reg <= 8'h00;
    else if (base_tick)
      cnt_reg <= cnt_next;
  end

endmodule

// ### rrt_regs.sv
// Rate conversion, settle, trim, test pattern and state readout registers.
//
// Operation
// - Base rates 50/100/200/400 kbps come straight from the three-bit base field.
// - Effective rate is base times (multiplier+1) over (divisor+1), divisor above multiplier.
// - A counter cycles over divisor+1 pulses, passing those below multiplier+1.
// - Converted timing is not PLL locked; jitter is divisor minus multiplier periods.
// - Settle wait field: 00 2ms, 01 1.3ms, 10 1ms, 11 0.6ms; resets 11.
// - Converter clock select bit picks 1.8 MHz clear, 2.0 MHz set; resets clear.
// - Test register: bit 0 enable, bits 1-5 and 7 select patterns.
// - With several selects set, only the lowest-numbered one counts.
// - Test patterns go out at the base field bit rate.
// - Meter PN9 feeds stage D4 into the feedback XOR.
// - State readout 0x00 means idle, after off command and engine reset.
// - Transmit states report codes 0x01 to 0x09 and 0x0B.
// - Receive states report 0x11, 0x14-0x19, 0x1C, 0x1D and 0x1F.
// - Bit 5 of the state register shows preamble match, independent of sync count.
`timescale 1ns/1ps
module rrt_regs
  import rrt_pkg::*;
#(
  parameter int SETTLE_00_CYC = RRT_SETTLE_00_CYC,
  parameter int SETTLE_01_CYC = RRT_SETTLE_01_CYC,
  parameter int SETTLE_10_CYC = RRT_SETTLE_10_CYC,
  parameter int SETTLE_11_CYC = RRT_SETTLE_11_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Register port behind the serial interface
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            reg_hit,
  // Oscillator control
  input  wire logic       osc_restart,
  output logic            clk_stable,
  output logic            adc_clk_high,
  output logic [6:0]      load_cap_trim,
  // Data rate
  input  wire logic [2:0] base_rate_sel,
  input  wire logic       base_tick,
  input  wire logic       frac_enable,
  output logic            rate_tick,
  output logic [2:0]      rate_sel_out,
  // Test pattern
  output logic            test_active,
  output logic            carrier_on,
  output logic            test_bit,
  output logic [2:0]      test_pattern,
  // Frame engine monitor
  input  wire logic [4:0] frame_engine_state,
  input  wire logic       preamble_match,
  output logic            state_code_known
);

  // Stored registers.
  logic [7:0] mult_reg;
  logic [7:0] div_reg;
  logic [7:0] settle_reg;
  logic [7:0] trim_reg;
  logic [7:0] test_reg;
  logic [1:0] state_rsv_reg;
  logic [4:0] state_snap_reg;
  logic       preamble_seen_flag_reg;
  logic [7:0] rdata_reg;
  logic       hit_reg;
  logic       known_reg;

  // Address decode.
  wire sel_mult   = (reg_addr == RRT_OFS_MULT);
  wire sel_div    = (reg_addr == RRT_OFS_DIV);
  wire sel_settle = (reg_addr == RRT_OFS_SETTLE);
  wire sel_trim   = (reg_addr == RRT_OFS_TRIM);
  wire sel_test   = (reg_addr == RRT_OFS_TEST);
  wire sel_state  = (reg_addr == RRT_OFS_STATE);
  wire sel_any    = sel_mult | sel_div | sel_settle | sel_trim | sel_test | sel_state;

  // Field views.
  wire [1:0] settle_wait_select = settle_reg[RRT_SETTLE_SEL_LSB +: 2];
  wire       pn9_pattern_select  = test_reg[1];
  wire       all_ones_select     = test_reg[2];
  wire       all_zeros_select    = test_reg[3];
  wire       alternating_select  = test_reg[4];
  wire       carrier_select      = test_reg[5];
  wire       meter_pn9_select    = test_reg[7];
  wire       test_en             = test_reg[RRT_TEST_EN_BIT];

  // Register writes; reserved bits that are writable simply hold what is written.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      mult_reg      <= RRT_RST_MULT;
      div_reg       <= RRT_RST_DIV;
      settle_reg    <= RRT_RST_SETTLE;
      trim_reg      <= RRT_RST_TRIM;
      test_reg      <= RRT_RST_TEST;
      state_rsv_reg <= RRT_RST_STATE[7:6];
    end
    else if (reg_wr)
    begin
      if (sel_mult)
        mult_reg <= reg_wdata;
      if (sel_div)
        div_reg <= reg_wdata;
      if (sel_settle)
        settle_reg <= reg_wdata & RRT_SETTLE_WMASK;
      if (sel_trim)
        trim_reg <= reg_wdata;
      if (sel_test)
        test_reg <= reg_wdata;
      if (sel_state)
        state_rsv_reg <= reg_wdata[7:6];
    end
  end

  // Live snapshot of the frame engine; the low bits follow the engine, not writes.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_snap_reg         <= RRT_ST_IDLE;
      preamble_seen_flag_reg <= 1'b0;
    end
    else
    begin
      state_snap_reg         <= frame_engine_state;
      preamble_seen_flag_reg <= preamble_match;
    end
  end

  // Flags a readout code outside the known set so debug software can reread.
  function automatic logic code_known(input logic [4:0] c);
    unique case (c)
      RRT_ST_IDLE, RRT_ST_TX_DATAW, RRT_ST_TX_PRE, RRT_ST_TX_SFD, RRT_ST_TX_LEN,
      RRT_ST_TX_PAY, RRT_ST_TX_CRC, RRT_ST_TX_POST, RRT_ST_TX_OFF, RRT_ST_TX_DIO,
      RRT_ST_TX_DONE, RRT_ST_RX_SFDW, RRT_ST_RX_LEN, RRT_ST_RX_PAY, RRT_ST_RX_CRC,
      RRT_ST_RX_POST, RRT_ST_RX_OFF, RRT_ST_RX_DIO, RRT_ST_RX_DIV1, RRT_ST_RX_DIV2,
      RRT_ST_RX_FEC:
        code_known = 1'b1;
      default:
        code_known = 1'b0;
    endcase
  endfunction

  always_ff @(posedge clk)
  begin
    if (!nrst)
      known_reg <= 1'b1;
    else
      known_reg <= code_known(state_snap_reg);
  end

  assign state_code_known = known_reg;

  // Read multiplexer; an unmapped address answers zero with no hit.
  wire [7:0] state_word = {state_rsv_reg, preamble_seen_flag_reg, state_snap_reg};
  wire [7:0] rd_mux = sel_mult   ? mult_reg   :
                      sel_div    ? div_reg    :
                      sel_settle ? settle_reg :
                      sel_trim   ? trim_reg   :
                      sel_test   ? test_reg   :
                      sel_state  ? state_word : 8'h00;

  // Read data is registered and holds until the next read.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rdata_reg <= 8'h00;
      hit_reg   <= 1'b0;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rd_mux;
      hit_reg   <= sel_any;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_hit   = hit_reg;

  // Settle wait selection: the length is latched when a wait starts.
  wire [RRT_SETTLE_W-1:0] settle_len =
    (settle_wait_select == 2'b00) ? RRT_SETTLE_W'(SETTLE_00_CYC) :
    (settle_wait_select == 2'b01) ? RRT_SETTLE_W'(SETTLE_01_CYC) :
    (settle_wait_select == 2'b10) ? RRT_SETTLE_W'(SETTLE_10_CYC) :
                                    RRT_SETTLE_W'(SETTLE_11_CYC);

  rrt_osc_e               osc_reg;
  rrt_osc_e               osc_next;
  logic [RRT_SETTLE_W-1:0] wait_reg;
  logic [RRT_SETTLE_W-1:0] wait_next;

  // The timer counts down; register access stays open during the wait.
  always_comb
  begin
    osc_next  = osc_reg;
    wait_next = wait_reg;
    unique case (osc_reg)
      RRT_OSC_WAIT:
      begin
        if (wait_reg <= RRT_SETTLE_W'(1))
          osc_next = RRT_OSC_STABLE;
        else
          wait_next = wait_reg - RRT_SETTLE_W'(1);
      end
      RRT_OSC_STABLE:
      begin
        wait_next = settle_len;
      end
    endcase
    if (osc_restart)
    begin
      osc_next  = RRT_OSC_WAIT;
      wait_next = settle_len;
    end
  end

  // After reset the wait uses the reset selection, the shortest one.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      osc_reg  <= RRT_OSC_WAIT;
      wait_reg <= RRT_SETTLE_W'(SETTLE_11_CYC);
    end
    else
    begin
      osc_reg  <= osc_next;
      wait_reg <= wait_next;
    end
  end

  assign clk_stable = (osc_reg == RRT_OSC_STABLE);

  // Oscillator and converter settings out.
  assign adc_clk_high  = settle_reg[RRT_ADC_CLK_BIT];
  assign load_cap_trim = trim_reg[6:0];

  // Fractional converter; bypassed when not asked for so fixed rates are untouched.
  logic gated_tick;

  rrt_rate_gate u_gate (
    .clk       (clk),
    .nrst      (nrst),
    .mult      (mult_reg),
    .div       (div_reg),
    .base_tick (base_tick),
    .rate_tick (gated_tick)
  );

  assign rate_tick    = frac_enable ? gated_tick : base_tick;
  assign rate_sel_out = base_rate_sel;

  // Priority encoder: the lowest set select bit wins; bit 6 is reserved.
  wire [2:0] pat_pick = pn9_pattern_select ? RRT_PAT_PN9     :
                        all_ones_select    ? RRT_PAT_ONES    :
                        all_zeros_select   ? RRT_PAT_ZEROS   :
                        alternating_select ? RRT_PAT_ALT     :
                        carrier_select     ? RRT_PAT_CARRIER :
                        meter_pn9_select   ? RRT_PAT_MPN9    : RRT_PAT_NONE;
  wire [2:0] pat_sel  = test_en ? pat_pick : RRT_PAT_NONE;

  // Patterns step on the base pulse, not the converted one.
  rrt_pattern_gen u_pat (
    .clk      (clk),
    .nrst     (nrst),
    .pat_sel  (pat_sel),
    .bit_tick (base_tick),
    .pat_bit  (test_bit)
  );

  // Pattern status flags are registered so they change with the pattern itself.
  logic       active_reg;
  logic       carrier_reg;
  logic [2:0] pattern_reg;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      active_reg  <= 1'b0;
      carrier_reg <= 1'b0;
      pattern_reg <= RRT_PAT_NONE;
    end
    else
    begin
      active_reg  <= (pat_sel != RRT_PAT_NONE);
      carrier_reg <= (pat_sel == RRT_PAT_CARRIER);
      pattern_reg <= pat_sel;
    end
  end

  assign test_active  = active_reg;
  assign carrier_on   = carrier_reg;
  assign test_pattern = pattern_reg;

endmodule

// ### rrt_regs_sva.sv
// Concurrent checks on the register slice top-level ports.
`timescale 1ns/1ps
module rrt_regs_sva
  import rrt_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       nrst,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_hit,
  // Oscillator, rate and test
  input wire logic       osc_restart,
  input wire logic       clk_stable,
  input wire logic       adc_clk_high,
  input wire logic [6:0] load_cap_trim,
  input wire logic       base_tick,
  input wire logic       frac_enable,
  input wire logic       rate_tick,
  input wire logic       test_bit,
  input wire logic [2:0] test_pattern,
  // Monitor inputs
  input wire logic [4:0] frame_engine_state,
  input wire logic       preamble_match
);
  logic        map_hit;
  logic [15:0] ratio_reg;
  logic [15:0] ratio_next;

  // Shadow of multiplier and divisor, followed from the write strobes.
  assign map_hit = reg_addr inside {RRT_OFS_MULT, RRT_OFS_DIV, RRT_OFS_SETTLE,
                                    RRT_OFS_TRIM, RRT_OFS_TEST, RRT_OFS_STATE};
  assign ratio_next = !reg_wr ? ratio_reg :
                      reg_addr == RRT_OFS_MULT ? {reg_wdata, ratio_reg[7:0]} :
                      reg_addr == RRT_OFS_DIV ? {ratio_reg[15:8], reg_wdata} : ratio_reg;

  // Shadow register update.
  always_ff @(posedge clk)
    ratio_reg <= !nrst ? 16'h0000 : ratio_next;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  base_pass_a: assert property (!frac_enable |-> rate_tick == base_tick)
    else $error("base pulse not passed straight");
  no_spur_a: assert property (!base_tick |-> !rate_tick)
    else $error("rate pulse without base pulse");
  zero_ratio_a: assert property (frac_enable && base_tick && ratio_reg == 16'h0000
    |-> rate_tick)
    else $error("zero ratio dropped a pulse");
  map_read_a: assert property (reg_rd && map_hit |=> reg_hit)
    else $error("mapped read not flagged");
  unmap_read_a: assert property (reg_rd && !map_hit |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not empty");
  adc_sel_a: assert property (reg_wr && reg_addr == RRT_OFS_SETTLE |=>
    adc_clk_high == $past(reg_wdata[4]) && $past(reg_wdata[4]) == adc_clk_high)
    else $error("converter clock select not taken");
  trim_wr_a: assert property (reg_wr && reg_addr == RRT_OFS_TRIM |=>
    load_cap_trim == $past(reg_wdata[6:0]))
    else $error("load trim not taken");
  state_rd_a: assert property (reg_rd && reg_addr == RRT_OFS_STATE
    && $stable(frame_engine_state) && $stable(preamble_match) |=>
    reg_rdata[5:0] == {$past(preamble_match, 2), $past(frame_engine_state, 2)})
    else $error("state readout wrong");
  ones_bit_a: assert property (base_tick && test_pattern == RRT_PAT_ONES
    && $stable(test_pattern) |-> ##2 test_bit)
    else $error("all-ones pattern gave zero");
  lowest_sel_a: assert property (reg_wr && reg_addr == RRT_OFS_TEST
    && reg_wdata[1:0] == 2'b11 |-> ##2 test_pattern == RRT_PAT_PN9)
    else $error("lowest select not honoured");
  restart_a: assert property (osc_restart |=> !clk_stable)
    else $error("restart left clock stable");
endmodule

bind rrt_regs rrt_regs_sva u_sva (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .reg_hit(reg_hit), .osc_restart(osc_restart), .clk_stable(clk_stable),
  .adc_clk_high(adc_clk_high), .load_cap_trim(load_cap_trim), .base_tick(base_tick),
  .frac_enable(frac_enable), .rate_tick(rate_tick), .test_bit(test_bit),
  .test_pattern(test_pattern), .frame_engine_state(frame_engine_state),
  .preamble_match(preamble_match));
